/* File: bsm_board_model.sv */
/*
 Board model: strap pulls, reset pin, serial host, flash restore engine, persistent cell.
 Assumes the bench sets the board levels; doneWait of zero means the engine never ends.
*/
`timescale 1ns/10ps
module bsm_board_model (
	input wire clk_sys,
	input wire rst_b,
	input wire [2:0] strapCode,
	input wire resetHeld,
	input wire breakOn,
	input wire [15:0] doneWait,
	input wire restorePersistOut,
	output reg [2:0] bootStrapPins,
	output reg externalResetLow,
	output reg serialRx,
	output reg restorePersistIn,
	output reg restoreDone
);
	reg prevOut = 1'b0;
	reg [15:0] busyCnt = 16'h0;
	initial begin
		bootStrapPins = 3'h0;
		externalResetLow = 1'b0;
		serialRx = 1'b1;
		restorePersistIn = 1'b0;
		restoreDone = 1'b0;
	end
	always @(posedge clk_sys) begin
		bootStrapPins <= strapCode;
		externalResetLow <= !resetHeld;
		serialRx <= !breakOn;
		prevOut <= restorePersistOut;
		// Cell only takes writes while powered, so it survives a power cycle
		if (rst_b && restorePersistOut != prevOut)
			restorePersistIn <= restorePersistOut;
		busyCnt <= restorePersistOut ? busyCnt + 16'h1 : 16'h0;
		restoreDone <= doneWait != 16'h0 && busyCnt == doneWait;
	end
endmodule // bsm_board_model

/* File: bsm_boot_strap_mode_select.v */
/*
 Boot strap mode selector: latches strap pins, picks boot flow and debug mapping,
 supervises the factory restore and guards the factory image sector.
 Assumes a Wishbone classic master, a flash controller that reports restore progress,
 and a persistent flag cell that survives power loss.
*/
`timescale 1ns/10ps
`include "bsm_defines.vh"

module bsm_boot_strap_mode_select #(
	parameter RESTORE_CYC = `BSM_RESTORE_CYC,
	parameter BREAK_CYC = `BSM_BREAK_CYC,
	parameter [23:0] IMAGE_BASE = 24'h0f0000,
	parameter [23:0] IMAGE_LAST = 24'h0fffff
) (
	clk_sys,
	rst_b,
	bootStrapPins,
	externalResetLow,
	serialRx,
	wb_cyc_i,
	wb_stb_i,
	wb_we_i,
	wb_adr_i,
	wb_sel_i,
	wb_dat_i,
	wb_dat_o,
	wb_ack_o,
	hostFlashReq,
	hostFlashAddr,
	hostFlashGrant,
	hostFlashDenied,
	restorePersistIn,
	restorePersistOut,
	restoreStart,
	restoreLevel,
	restoreDone,
	bootFlow,
	debugTwoWire,
	serialLoadActive,
	strapBitTwoOe
);
	input wire clk_sys;
	input wire rst_b;
	input wire [2:0] bootStrapPins;
	input wire externalResetLow;
	input wire serialRx;
	input wire wb_cyc_i;
	input wire wb_stb_i;
	input wire wb_we_i;
	input wire [7:0] wb_adr_i;
	input wire [3:0] wb_sel_i;
	input wire [31:0] wb_dat_i;
	output reg [31:0] wb_dat_o;
	output reg wb_ack_o;
	input wire hostFlashReq;
	input wire [23:0] hostFlashAddr;
	output reg hostFlashGrant;
	output reg hostFlashDenied;
	input wire restorePersistIn;
	output reg restorePersistOut;
	output reg restoreStart;
	output reg [1:0] restoreLevel;
	input wire restoreDone;
	output reg [2:0] bootFlow;
	output reg debugTwoWire;
	output reg serialLoadActive;
	output reg strapBitTwoOe;

	localparam [4:0] ST_SENSE = 5'h01;
	localparam [4:0] ST_HOLD = 5'h02;
	localparam [4:0] ST_RUN = 5'h04;
	localparam [4:0] ST_RESTORE = 5'h08;
	localparam [4:0] ST_BREAK = 5'h10;
	// Restore limit is cut to 32 bits and break limit to the 24-bit counter width on purpose
	localparam [39:0] RESTORE_LIMIT = {8'h0, RESTORE_CYC[31:0]};
	localparam [23:0] BREAK_LIMIT = BREAK_CYC[23:0];

	function inSector;
		input [23:0] addr;
		begin
			inSector = (addr >= IMAGE_BASE) && (addr <= IMAGE_LAST);
		end
	endfunction

	wire [2:0] strapSync;
	wire resetLowSync;
	wire rxSync;

	// Strap pins feed sensing only; just bit two gets an output enable
	bsm_pin_sync #(.WIDTH(3), .INIT(3'h0)) uStrap (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.pinIn(bootStrapPins),
		.pinOut(strapSync)
	);
	bsm_pin_sync #(.WIDTH(2), .INIT(2'h3)) uCtl (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.pinIn({externalResetLow, serialRx}),
		.pinOut({resetLowSync, rxSync})
	);

	reg [4:0] state_reg;
	reg [2:0] code_reg;
	reg [2:0] settle_reg;
	reg resetLowPrev_reg;
	reg [39:0] restoreCnt_reg;
	reg [23:0] breakCnt_reg;
	reg restoreFail_reg;
	reg restoreOk_reg;
	reg [1:0] level_reg;
	reg swStart_reg;

	wire resetRise = resetLowSync && !resetLowPrev_reg;
	wire resetFall = !resetLowSync && resetLowPrev_reg;
	wire wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;

	////////////////////////////////////////////////////////////////////////////////
	// Strap latch and boot flow

	always @(posedge clk_sys) begin
		if (!rst_b) begin
			state_reg <= ST_SENSE;
			code_reg <= `BSM_CODE_RUN_FOUR;
			settle_reg <= 3'h0;
			// Matches the synchroniser idle level so reset brings no false edge
			resetLowPrev_reg <= 1'b1;
			restoreCnt_reg <= 40'h0;
			breakCnt_reg <= 24'h0;
			restoreFail_reg <= 1'b0;
			restoreOk_reg <= 1'b0;
			bootFlow <= `BSM_FLOW_RESERVED;
			debugTwoWire <= `BSM_DBG_FOUR;
			serialLoadActive <= 1'b0;
			restoreStart <= 1'b0;
			restorePersistOut <= 1'b0;
			restoreLevel <= `BSM_LVL_NONE;
			strapBitTwoOe <= 1'b0;
		end else begin
			resetLowPrev_reg <= resetLowSync;
			restoreStart <= 1'b0;
			case (state_reg)
				ST_SENSE: begin
					// Wait for synchroniser to fill, then latch while reset still held
					settle_reg <= settle_reg + 3'h1;
					if (settle_reg == 3'h5) begin
						code_reg <= strapSync;
						state_reg <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					if (!resetLowSync)
						code_reg <= strapSync;
					else begin
						strapBitTwoOe <= 1'b1;
						// Mapping comes from the latch only
						debugTwoWire <= (code_reg == `BSM_CODE_RUN_TWO) ?
							`BSM_DBG_TWO : `BSM_DBG_FOUR;
						if (restorePersistIn) begin
							// Interrupted restore resumes first
							state_reg <= ST_RESTORE;
							restoreOk_reg <= 1'b0;
							restoreFail_reg <= 1'b0;
							restoreStart <= 1'b1;
							restoreLevel <= `BSM_LVL_IMAGE;
							restorePersistOut <= 1'b1;
							restoreCnt_reg <= 40'h0;
							bootFlow <= `BSM_FLOW_RESTORE;
						end else if (resetRise && code_reg == `BSM_CODE_RESTORE) begin
							state_reg <= ST_RESTORE;
							restoreOk_reg <= 1'b0;
							restoreFail_reg <= 1'b0;
							restoreStart <= 1'b1;
							restoreLevel <= `BSM_LVL_IMAGE;
							restorePersistOut <= 1'b1;
							restoreCnt_reg <= 40'h0;
							bootFlow <= `BSM_FLOW_RESTORE;
						end else if (code_reg == `BSM_CODE_SERIAL_LOAD) begin
							// Waits for serial code indefinitely
							bootFlow <= `BSM_FLOW_SERIAL_LOAD;
							serialLoadActive <= 1'b1;
							state_reg <= ST_RUN;
						end else if (code_reg == `BSM_CODE_LOAD_OR_RUN) begin
							breakCnt_reg <= 24'h0;
							state_reg <= ST_BREAK;
						end else if (code_reg == `BSM_CODE_RUN_TWO ||
							code_reg == `BSM_CODE_RUN_FOUR) begin
							bootFlow <= `BSM_FLOW_RUN;
							state_reg <= ST_RUN;
						end else begin
							bootFlow <= `BSM_FLOW_RESERVED;
							state_reg <= ST_RUN;
						end
					end
				end
				ST_BREAK: begin
					// Receive held low for the break time means a serial load
					// Any high sample on the filtered receive line (rxSync) means no break
					if (rxSync) begin
						bootFlow <= `BSM_FLOW_RUN;
						state_reg <= ST_RUN;
					end else if (breakCnt_reg == BREAK_LIMIT - 24'h1) begin
						bootFlow <= `BSM_FLOW_SERIAL_LOAD;
						serialLoadActive <= 1'b1;
						state_reg <= ST_RUN;
					end else
						breakCnt_reg <= breakCnt_reg + 24'h1;
				end
				ST_RESTORE: begin
					// Done wins over the limit when both land in one cycle
					if (restoreDone) begin
						restorePersistOut <= 1'b0;
						restoreOk_reg <= 1'b1;
						restoreLevel <= `BSM_LVL_NONE;
						bootFlow <= `BSM_FLOW_RUN;
						state_reg <= ST_RUN;
					end else if (restoreCnt_reg >= RESTORE_LIMIT) begin
						// Only judged failed after the full restore allowance; flag kept
						restoreFail_reg <= 1'b1;
						bootFlow <= `BSM_FLOW_RESTORE_FAIL;
						state_reg <= ST_RUN;
					end else
						restoreCnt_reg <= restoreCnt_reg + 40'h1;
				end
				ST_RUN: begin
					if (swStart_reg) begin
						state_reg <= ST_RESTORE;
						restoreStart <= 1'b1;
						restoreLevel <= level_reg;
						restorePersistOut <= 1'b1;
						restoreCnt_reg <= 40'h0;
						restoreOk_reg <= 1'b0;
						restoreFail_reg <= 1'b0;
						bootFlow <= `BSM_FLOW_RESTORE;
						// Software restore leaves any serial load flow
						serialLoadActive <= 1'b0;
					end else if (resetFall) begin
						// External reset re-latches the straps
						state_reg <= ST_HOLD;
						serialLoadActive <= 1'b0;
						strapBitTwoOe <= 1'b0;
						code_reg <= strapSync;
					end
				end
				default: state_reg <= ST_SENSE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Factory image sector guard
	// Grant and deny come from one registered decode of the same address

	always @(posedge clk_sys) begin
		if (!rst_b) begin
			hostFlashGrant <= 1'b0;
			hostFlashDenied <= 1'b0;
		end else begin
			hostFlashGrant <= hostFlashReq && !inSector(hostFlashAddr);
			hostFlashDenied <= hostFlashReq && inSector(hostFlashAddr);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Wishbone slave, one wait state

	always @(posedge clk_sys) begin
		if (!rst_b) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			swStart_reg <= 1'b0;
			level_reg <= `BSM_LVL_PARAMS;
		end else begin
			wb_ack_o <= wbReq;
			swStart_reg <= 1'b0;
			wb_dat_o <= 32'h0;
			// Start is a one-cycle pulse; a zero level never starts a restore
			if (wbReq && wb_we_i && wb_adr_i == `BSM_REG_CONTROL && wb_sel_i[0]) begin
				level_reg <= wb_dat_i[`BSM_CTRL_LVL_LSB +: 2];
				swStart_reg <= wb_dat_i[`BSM_CTRL_START_BIT] &&
					wb_dat_i[`BSM_CTRL_LVL_LSB +: 2] != `BSM_LVL_NONE;
			end
			if (wbReq && !wb_we_i) begin
				case (wb_adr_i)
					`BSM_REG_STATUS: begin
						wb_dat_o[`BSM_STAT_CODE_LSB +: 3] <= code_reg;
						wb_dat_o[`BSM_STAT_FLOW_LSB +: 3] <= bootFlow;
						wb_dat_o[`BSM_STAT_DBG_BIT] <= debugTwoWire;
						wb_dat_o[`BSM_STAT_BUSY_BIT] <= (state_reg == ST_RESTORE);
						wb_dat_o[`BSM_STAT_DONE_BIT] <= restoreOk_reg;
						wb_dat_o[`BSM_STAT_FAIL_BIT] <= restoreFail_reg;
						wb_dat_o[`BSM_STAT_PEND_BIT] <= restorePersistOut;
					end
					`BSM_REG_CONTROL: wb_dat_o[`BSM_CTRL_LVL_LSB +: 2] <= level_reg;
					`BSM_REG_PROTECT: wb_dat_o[23:0] <= IMAGE_BASE;
					default: wb_dat_o <= 32'h0;
				endcase
			end
		end
	end
endmodule // bsm_boot_strap_mode_select

/* File: bsm_boot_strap_mode_select_tb_top.sv */
/*
 Self-checking bench for the boot strap mode selector.
 Assumes short restore and break counts set through parameters.
*/
`timescale 1ns/10ps
module bsm_boot_strap_mode_select_tb_top;
	reg clk_sys = 1'b0;
	reg rst_b = 1'b0;
	reg [2:0] strapCode = 3'h0;
	reg resetHeld = 1'b1;
	reg breakOn = 1'b0;
	reg [15:0] doneWait = 16'h0;
	reg wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	reg [7:0] wb_adr_i = 8'h00;
	reg [3:0] wb_sel_i = 4'hf;
	reg [31:0] wb_dat_i = 32'h0, rd;
	reg hostFlashReq = 1'b0;
	reg [23:0] hostFlashAddr = 24'h0;
	wire [31:0] wb_dat_o;
	wire wb_ack_o, hostFlashGrant, hostFlashDenied, restorePersistIn, restorePersistOut;
	wire restoreStart, restoreDone, debugTwoWire, serialLoadActive, externalResetLow, serialRx;
	wire strapBitTwoOe;
	wire [2:0] bootStrapPins, bootFlow;
	wire [1:0] restoreLevel;
	integer err_count = 0;
	integer n_compared = 0;
	localparam [17:0] MCODE = {3'h6, 3'h2, 3'h2, 3'h0, 3'h1, 3'h4};
	localparam [17:0] MFLOW = {3'h0, 3'h1, 3'h2, 3'h2, 3'h2, 3'h1};
	localparam [5:0] MBRK = 6'h10, MDBG = 6'h02, MSER = 6'h11;
	always #4 clk_sys = ~clk_sys;
	bsm_boot_strap_mode_select #(.RESTORE_CYC(200), .BREAK_CYC(20)) u_bsm_boot_strap_mode_select (
		.clk_sys(clk_sys), .rst_b(rst_b), .bootStrapPins(bootStrapPins),
		.externalResetLow(externalResetLow), .serialRx(serialRx), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.hostFlashReq(hostFlashReq), .hostFlashAddr(hostFlashAddr),
		.hostFlashGrant(hostFlashGrant), .hostFlashDenied(hostFlashDenied),
		.restorePersistIn(restorePersistIn), .restorePersistOut(restorePersistOut),
		.restoreStart(restoreStart), .restoreLevel(restoreLevel), .restoreDone(restoreDone),
		.bootFlow(bootFlow), .debugTwoWire(debugTwoWire),
		.serialLoadActive(serialLoadActive), .strapBitTwoOe(strapBitTwoOe));
	bsm_board_model u_bsm_board_model (.clk_sys(clk_sys), .rst_b(rst_b),
		.strapCode(strapCode), .resetHeld(resetHeld), .breakOn(breakOn), .doneWait(doneWait),
		.restorePersistOut(restorePersistOut), .bootStrapPins(bootStrapPins),
		.externalResetLow(externalResetLow), .serialRx(serialRx),
		.restorePersistIn(restorePersistIn), .restoreDone(restoreDone));
	////////////////////////////////////////////////////////////////////////////////
	task final_report;
		$display("mismatches %0d, compares %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task check(input string name, input [31:0] seen, input [31:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task wbXfer(input we, input [7:0] a, input [31:0] d, output [31:0] r);
		integer i;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		i = 0;
		@(posedge clk_sys);
		while (wb_ack_o !== 1'b1 && i < 20) begin
			@(posedge clk_sys);
			i = i + 1;
		end
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_sys);
		check("wbAck", i < 20, 1'b1);
		if (i == 20)
			final_report;
	endtask
	task waitFlow(input [2:0] f);
		integer i;
		i = 0;
		while (bootFlow !== f && i < 400) begin
			@(posedge clk_sys);
			i = i + 1;
		end
		check("bootFlow", bootFlow, f);
		if (i == 400)
			final_report;
	endtask
	// Power cycle with the board levels set, then release the external reset
	task boot(input [2:0] c, input b, input [15:0] w);
		strapCode <= c;
		breakOn <= b;
		doneWait <= w;
		resetHeld <= 1'b1;
		rst_b <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (10) @(posedge clk_sys);
		resetHeld <= 1'b0;
		repeat (8) @(posedge clk_sys);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task sc_modes;
		integer k;
		for (k = 0; k < 6; k = k + 1) begin
			boot(MCODE[3*k +: 3], MBRK[k], 16'h0);
			waitFlow(MFLOW[3*k +: 3]);
			check("debugTwoWire", debugTwoWire, MDBG[k]);
			check("serialLoad", serialLoadActive, MSER[k]);
			check("strapTwoOe", strapBitTwoOe, 1'b1);
			strapCode <= ~MCODE[3*k +: 3];
			wbXfer(1'b1, 8'h00, 32'hffffffff, rd);
			wbXfer(1'b0, 8'h00, 32'h0, rd);
			check("latchedCode", rd[2:0], MCODE[3*k +: 3]);
			check("flowHeld", bootFlow, MFLOW[3*k +: 3]);
		end
	endtask
	task sc_restore;
		boot(3'h3, 1'b0, 16'd40);
		waitFlow(3'h3);
		check("hwLevel", restoreLevel, 2'h2);
		waitFlow(3'h2);
		wbXfer(1'b0, 8'h00, 32'h0, rd);
		check("doneBit", rd[10], 1'b1);
		wbXfer(1'b0, 8'h04, 32'h0, rd);
		check("ctrlLevel", rd[5:4], 2'h1);
		wbXfer(1'b1, 8'h04, 32'h12, rd);
		waitFlow(3'h3);
		check("swLevel", restoreLevel, 2'h1);
		waitFlow(3'h2);
		wbXfer(1'b0, 8'h0c, 32'h0, rd);
		check("unmapped", rd, 32'h0);
		wbXfer(1'b0, 8'h08, 32'h0, rd);
		check("protectBase", rd[23:0], 24'h0f0000);
		strapCode <= 3'h1;
		resetHeld <= 1'b1;
		repeat (10) @(posedge clk_sys);
		resetHeld <= 1'b0;
		repeat (8) @(posedge clk_sys);
		check("relatchDbg", debugTwoWire, 1'b1);
		check("relatchFlow", bootFlow, 3'h2);
		wbXfer(1'b0, 8'h00, 32'h0, rd);
		check("relatched", rd[2:0], 3'h1);
	endtask
	task sc_failResume;
		boot(3'h3, 1'b0, 16'h0);
		waitFlow(3'h3);
		waitFlow(3'h4);
		check("persistKept", restorePersistOut, 1'b1);
		boot(3'h0, 1'b0, 16'd30);
		waitFlow(3'h3);
		waitFlow(3'h2);
	endtask
	task sc_guard;
		hostFlashReq <= 1'b1;
		hostFlashAddr <= 24'h0fffff;
		repeat (2) @(posedge clk_sys);
		check("denied", hostFlashDenied, 1'b1);
		check("deniedNoGrant", hostFlashGrant, 1'b0);
		hostFlashAddr <= 24'h0effff;
		repeat (2) @(posedge clk_sys);
		check("granted", hostFlashGrant, 1'b1);
		check("grantedNoDeny", hostFlashDenied, 1'b0);
		hostFlashReq <= 1'b0;
	endtask
	initial begin
		sc_modes;
		sc_restore;
		sc_failResume;
		sc_guard;
		final_report;
	end
endmodule // bsm_boot_strap_mode_select_tb_top

/* File: bsm_defines.vh */
/*
 Constants for the boot strap mode selector: strap codes, register map, timing counts.
 Assumes inclusion by bare name from every design file of the block.
*/
`ifndef BSM_DEFINES_VH
`define BSM_DEFINES_VH

`define BSM_CODE_SERIAL_LOAD 3'h4
`define BSM_CODE_RUN_TWO 3'h1
`define BSM_CODE_RUN_FOUR 3'h0
`define BSM_CODE_LOAD_OR_RUN 3'h2
`define BSM_CODE_RESTORE 3'h3

`define BSM_FLOW_RESERVED 3'h0
`define BSM_FLOW_SERIAL_LOAD 3'h1
`define BSM_FLOW_RUN 3'h2
`define BSM_FLOW_RESTORE 3'h3
`define BSM_FLOW_RESTORE_FAIL 3'h4

`define BSM_DBG_FOUR 1'b0
`define BSM_DBG_TWO 1'b1

`define BSM_LVL_NONE 2'h0
`define BSM_LVL_PARAMS 2'h1
`define BSM_LVL_IMAGE 2'h2

`define BSM_REG_STATUS 8'h00
`define BSM_REG_CONTROL 8'h04
`define BSM_REG_PROTECT 8'h08

`define BSM_STAT_CODE_LSB 0
`define BSM_STAT_FLOW_LSB 4
`define BSM_STAT_DBG_BIT 8
`define BSM_STAT_BUSY_BIT 9
`define BSM_STAT_DONE_BIT 10
`define BSM_STAT_FAIL_BIT 11
`define BSM_STAT_PEND_BIT 12
`define BSM_CTRL_DONE_BIT 0
`define BSM_CTRL_START_BIT 1
`define BSM_CTRL_LVL_LSB 4

`define BSM_CLK_MHZ 125
`define BSM_RESTORE_S 8
`define BSM_RESTORE_CYC (`BSM_RESTORE_S * `BSM_CLK_MHZ * 1000000)
`define BSM_BREAK_US 100
`define BSM_BREAK_CYC (`BSM_BREAK_US * `BSM_CLK_MHZ)

`endif

/* File: bsm_mode_select_checker.sv */
/*
 Assertions on the boot strap mode selector ports, bound into its top module.
 Assumes the Wishbone master keeps one request at a time.
*/
`timescale 1ns/10ps
module bsm_mode_select_checker #(
	parameter [23:0] IMAGE_BASE = 24'h0f0000,
	parameter [23:0] IMAGE_LAST = 24'h0fffff
) (
	input wire clk_sys,
	input wire rst_b,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire hostFlashReq,
	input wire [23:0] hostFlashAddr,
	input wire hostFlashGrant,
	input wire hostFlashDenied,
	input wire restoreStart,
	input wire [1:0] restoreLevel,
	input wire restorePersistOut,
	input wire [2:0] bootFlow,
	input wire debugTwoWire,
	input wire serialLoadActive
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	wire inSector = hostFlashAddr >= IMAGE_BASE && hostFlashAddr <= IMAGE_LAST;
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	property p_ack; s_req |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_ackOnce; wb_ack_o |=> !wb_ack_o; endproperty
	a_ackOnce: assert property (p_ackOnce) else $error("ack too long");
	property p_deny; hostFlashReq && inSector |=> hostFlashDenied && !hostFlashGrant; endproperty
	a_deny: assert property (p_deny) else $error("sector access granted");
	property p_grant; hostFlashReq && !inSector |=> hostFlashGrant && !hostFlashDenied; endproperty
	a_grant: assert property (p_grant) else $error("access not granted");
	property p_start; restoreStart |=> !restoreStart; endproperty
	a_start: assert property (p_start) else $error("start not a pulse");
	property p_level; restoreStart |-> ##[0:1] (restoreLevel != 2'h0); endproperty
	a_level: assert property (p_level) else $error("restore with no level");
	property p_fail; bootFlow == 3'h4 |-> restorePersistOut; endproperty
	a_fail: assert property (p_fail) else $error("failed restore forgotten");
	property p_serial; serialLoadActive |-> bootFlow == 3'h1 && !debugTwoWire; endproperty
	a_serial: assert property (p_serial) else $error("serial load mapping");
endmodule // bsm_mode_select_checker

bind bsm_boot_strap_mode_select bsm_mode_select_checker #(.IMAGE_BASE(IMAGE_BASE),
	.IMAGE_LAST(IMAGE_LAST)) u_bsm_mode_select_checker (.clk_sys(clk_sys), .rst_b(rst_b),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.hostFlashReq(hostFlashReq), .hostFlashAddr(hostFlashAddr),
	.hostFlashGrant(hostFlashGrant), .hostFlashDenied(hostFlashDenied),
	.restoreStart(restoreStart), .restoreLevel(restoreLevel),
	.restorePersistOut(restorePersistOut), .bootFlow(bootFlow),
	.debugTwoWire(debugTwoWire), .serialLoadActive(serialLoadActive));

/* File: bsm_pin_sync.v */
/*
 Three-stage pin synchroniser with agreement filter.
 Assumes an asynchronous pin and a synchronous active-low reset.
*/
`timescale 1ns/10ps
`include "bsm_defines.vh"

module bsm_pin_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
	clk_sys,
	rst_b,
	pinIn,
	pinOut
);
	input wire clk_sys;
	input wire rst_b;
	input wire [WIDTH-1:0] pinIn;
	output reg [WIDTH-1:0] pinOut;

	reg [WIDTH-1:0] stageOne;
	reg [WIDTH-1:0] stageTwo;
	reg [WIDTH-1:0] stageThree;

	// Output follows once stages two and three agree
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			stageOne <= INIT;
			stageTwo <= INIT;
			stageThree <= INIT;
			pinOut <= INIT;
		end else begin
			stageOne <= pinIn;
			stageTwo <= stageOne;
			stageThree <= stageTwo;
			if (stageTwo == stageThree)
				pinOut <= stageThree;
		end
	end
endmodule // bsm_pin_sync
